// ==== pkg/nac_arr_if.sv ====
// array port between the control logic and the byte store
// assumes both ends share clock_i
`timescale 1ns/1ps
`default_nettype none
interface nac_arr_if;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;
  modport ctl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ==== pkg/nac_pkg.sv ====
// constants shared by the nvm access control block
// assumes a single 100 MHz system clock
package nac_pkg;
  localparam int          NAC_DEPTH        = 32;
  localparam int          NAC_AW           = 5;
  // sector 0 register indices, sector 1 control index
  localparam logic [8:0]  NAC_IDX_INDEX    = 9'h040;
  localparam logic [8:0]  NAC_IDX_BYTE     = 9'h041;
  localparam logic [8:0]  NAC_IDX_CONTROL  = 9'h140;
  // control field positions
  localparam int          NAC_BIT_FTRIG    = 0;
  localparam int          NAC_BIT_FPERMIT  = 1;
  localparam int          NAC_BIT_STRIG    = 2;
  localparam int          NAC_BIT_SPERMIT  = 3;
  localparam int          NAC_BIT_RSVD     = 7;
  // reset values
  localparam logic [7:0]  NAC_CONTROL_RST  = 8'h00;
  localparam logic [7:0]  NAC_BYTE_RST     = 8'h00;
  localparam logic [4:0]  NAC_INDEX_RST    = 5'h00;
  // timing
  localparam int          NAC_CLK_MHZ      = 100;
  localparam int          NAC_READ_NS      = 40;
  localparam int          NAC_READ_CYC     = (NAC_READ_NS*NAC_CLK_MHZ)/1000;
  localparam int          NAC_WRITE_US     = 2000;
  localparam int          NAC_WRITE_CYC    = NAC_WRITE_US * NAC_CLK_MHZ;
endpackage

// ==== rtl/nac_array.sv ====
// 32 byte nonvolatile store model, registered read
// assumes the control logic writes only one byte per write cycle
`timescale 1ns/1ps
`default_nettype none
module nac_array #(
  parameter int DEPTH = 32
) (
  input  wire logic clock_i,
  nac_arr_if.mem    arr
);
  logic [7:0] mem_reg [DEPTH];
  logic [7:0] rdata_reg;
  always_ff @(posedge clock_i) begin
    if (arr.we) begin
      mem_reg[arr.addr] <= arr.wdata;
    end
    rdata_reg <= mem_reg[arr.addr];
  end
  assign arr.rdata = rdata_reg;
endmodule // nac_array
`default_nettype wire

// ==== rtl/nac_ctrl.sv ====
// nvm access control: index, byte and control registers, read and
// write sequencing, completion flag.
// assumes the core gives one access per cycle on the sfr port, and that
// write timing arrives from an asynchronous timer as a done level toggle.
`timescale 1ns/1ps
`default_nettype none
module nac_ctrl #(
  parameter int READ_CYC = nac_pkg::NAC_READ_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [8:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            timer_start_o,
  input  wire logic       timer_done_i,
  input  wire logic       irq_mask_i,
  input  wire logic       global_irq_enable_i,
  input  wire logic       stack_full_i,
  input  wire logic       irq_ack_i,
  output logic            irq_req_o,
  output logic            nvm_irq_flag_o,
  output logic            global_irq_clear_o
);
  // ****************************************
  // registers and decode
  // ****************************************
  typedef enum logic [1:0] {NAC_IDLE, NAC_READ, NAC_WRITE} nac_state_t;
  nac_state_t state_reg;
  logic [4:0] index_reg;
  logic [7:0] byte_reg;
  logic       sp_reg, st_reg, fp_reg, ft_reg;
  logic       flag_reg;
  logic [15:0] cnt_reg;
  logic       done_m_reg, done_s_reg, done_d_reg;
  nac_arr_if  arr ();

  wire sel_index = sfr_addr_i == nac_pkg::NAC_IDX_INDEX;
  wire sel_byte  = sfr_addr_i == nac_pkg::NAC_IDX_BYTE;
  wire sel_ctl   = sfr_addr_i == nac_pkg::NAC_IDX_CONTROL;
  wire wr_ctl    = sfr_wr_i && sel_ctl;
  // a trigger only counts if its permit was already stored
  wire start_wr  = wr_ctl && sfr_wdata_i[nac_pkg::NAC_BIT_STRIG] && sp_reg
                   && (state_reg == NAC_IDLE);
  wire start_rd  = wr_ctl && sfr_wdata_i[nac_pkg::NAC_BIT_FTRIG] && fp_reg
                   && (state_reg == NAC_IDLE) && !start_wr;
  wire rd_end    = (state_reg == NAC_READ) && (cnt_reg == 16'h0000);
  wire done_edge = done_s_reg ^ done_d_reg;
  wire wr_end    = (state_reg == NAC_WRITE) && done_edge;
  wire [7:0] ctl_view = {4'h0, sp_reg, st_reg, fp_reg, ft_reg};
  wire [7:0] index_view = {3'h0, index_reg};
  assign sfr_rdata_o = sel_ctl ? ctl_view :
                       sel_byte ? byte_reg :
                       sel_index ? index_view : 8'h00;

  // ****************************************
  // sequencer
  // ****************************************
  // timer done is a toggle from the slow domain; resync before use
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_m_reg <= 1'b0;
      done_s_reg <= 1'b0;
      done_d_reg <= 1'b0;
    end else begin
      done_m_reg <= timer_done_i;
      done_s_reg <= done_m_reg;
      done_d_reg <= done_s_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= NAC_IDLE;
      cnt_reg   <= 16'h0000;
    end else begin
      unique case (state_reg)
        NAC_IDLE: begin
          if (start_rd) begin
            state_reg <= NAC_READ;
            cnt_reg   <= 16'(READ_CYC - 1);
          end else if (start_wr) begin
            state_reg <= NAC_WRITE;
          end
        end
        NAC_READ: begin
          if (rd_end) begin
            state_reg <= NAC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        NAC_WRITE: begin
          if (wr_end) begin
            state_reg <= NAC_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // control, index and byte registers
  // ****************************************
  // reset clears control
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_reg <= 1'b0;
      fp_reg <= 1'b0;
    end else if (wr_ctl) begin
      sp_reg <= sfr_wdata_i[nac_pkg::NAC_BIT_SPERMIT];
      fp_reg <= sfr_wdata_i[nac_pkg::NAC_BIT_FPERMIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= 1'b0;
      ft_reg <= 1'b0;
    end else begin
      // store trigger clears at write end
      if (start_wr) begin
        st_reg <= 1'b1;
      end else if (wr_end) begin
        st_reg <= 1'b0;
      end
      // fetch trigger clears at read end; no permit no read
      if (start_rd) begin
        ft_reg <= 1'b1;
      end else if (rd_end) begin
        ft_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_reg <= nac_pkg::NAC_INDEX_RST;
      byte_reg  <= nac_pkg::NAC_BYTE_RST;
    end else begin
      if (sfr_wr_i && sel_index) begin
        index_reg <= sfr_wdata_i[4:0];
      end
      if (rd_end) begin
        byte_reg <= arr.rdata;
      end else if (sfr_wr_i && sel_byte) begin
        byte_reg <= sfr_wdata_i;
      end
    end
  end

  assign arr.addr      = index_reg;
  assign arr.wdata     = byte_reg;
  assign arr.we        = start_wr;
  assign timer_start_o = start_wr;

  nac_array #(.DEPTH(nac_pkg::NAC_DEPTH)) u_array (
    .clock_i (clock_i),
    .arr     (arr)
  );

  // ****************************************
  // completion flag
  // ****************************************
  // set on write end; set beats acknowledge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 1'b0;
    end else if (wr_end) begin
      flag_reg <= 1'b1;
    end else if (irq_ack_i) begin
      flag_reg <= 1'b0;
    end
  end
  assign nvm_irq_flag_o     = flag_reg;
  assign irq_req_o          = flag_reg && irq_mask_i && global_irq_enable_i
                              && !stack_full_i;
  assign global_irq_clear_o = irq_ack_i;

  // ****************************************
  // checks
  // ****************************************
  property p_nopermit_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_ctl && !sp_reg) |-> !arr.we;
  endproperty
  a_nopermit_write: assert property (p_nopermit_write)
    else $error("write started without store permit");

  property p_nopermit_read;
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_ctl && !fp_reg && state_reg == NAC_IDLE) |=> !ft_reg;
  endproperty
  a_nopermit_read: assert property (p_nopermit_read)
    else $error("read started without fetch permit");

  property p_read_len;
    @(posedge clock_i) disable iff (!rst_n_i)
    start_rd |=> ft_reg [*4] ##1 !ft_reg;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read length wrong");

  property p_upper_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
    sel_ctl |-> sfr_rdata_o[6:4] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("control upper bits not zero");

  property p_wr_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_end |=> !st_reg && flag_reg;
  endproperty
  a_wr_clear: assert property (p_wr_clear)
    else $error("write end not reported");

  property p_byte_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    (!rd_end && !(sfr_wr_i && sel_byte)) |=> $stable(byte_reg);
  endproperty
  a_byte_hold: assert property (p_byte_hold)
    else $error("byte register changed");

  property p_st_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == NAC_WRITE && !wr_end) |=> st_reg;
  endproperty
  a_st_hold: assert property (p_st_hold)
    else $error("store trigger dropped early");

  property p_sp_gate;
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(st_reg) |-> $past(sp_reg);
  endproperty
  a_sp_gate: assert property (p_sp_gate)
    else $error("write start without permit");

  c_read:  cover property (@(posedge clock_i) disable iff (!rst_n_i) rd_end);
  c_write: cover property (@(posedge clock_i) disable iff (!rst_n_i) wr_end);
  c_irq:   cover property (@(posedge clock_i) disable iff (!rst_n_i)
                           irq_req_o);
endmodule // nac_ctrl
`default_nettype wire

// ==== verif/nac_ctrl_test.sv ====
// self-checking bench for nac_ctrl against an integer byte model
// assumes the timer model answers every write start
`timescale 1ns/1ps
`default_nettype none
module nac_ctrl_test;
  localparam logic [8:0] IX = nac_pkg::NAC_IDX_INDEX;
  localparam logic [8:0] BY = nac_pkg::NAC_IDX_BYTE;
  localparam logic [8:0] CT = nac_pkg::NAC_IDX_CONTROL;
  logic       clock_i             = 1'b0;
  logic       rst_n_i             = 1'b0;
  logic [8:0] sfr_addr_i          = 9'h000;
  logic       sfr_wr_i            = 1'b0;
  logic [7:0] sfr_wdata_i         = 8'h00;
  logic       irq_mask_i          = 1'b0;
  logic       global_irq_enable_i = 1'b0;
  logic       stack_full_i        = 1'b0;
  logic       irq_ack_i           = 1'b0;
  logic       tmr_slow            = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic       timer_start_o;
  logic       timer_done_i;
  logic       irq_req_o;
  logic       nvm_irq_flag_o;
  logic       global_irq_clear_o;
  logic [7:0] got;
  logic [31:0] dat;
  int         mem [32];
  int         addrs [4] = '{0, 31, 36, 7};
  int         starts, exp_starts, bad_count, compares;
  int         seed = 95143;

  always #5 clock_i = ~clock_i;

  nac_ctrl #(.READ_CYC(4)) dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .timer_start_o(timer_start_o),
    .timer_done_i(timer_done_i), .irq_mask_i(irq_mask_i),
    .global_irq_enable_i(global_irq_enable_i),
    .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
    .irq_req_o(irq_req_o), .nvm_irq_flag_o(nvm_irq_flag_o),
    .global_irq_clear_o(global_irq_clear_o));

  nac_timer_model tmr_u (.clock_i(clock_i), .start_i(timer_start_o),
    .slow_i(tmr_slow), .done_o(timer_done_i));

  always @(negedge clock_i) begin
    #3;
    if (timer_start_o === 1'b1) begin
      starts++;
    end
  end

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic put(input logic [8:0] a, input logic [7:0] d);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    @(negedge clock_i);
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    put(a, d);
    sfr_wr_i = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic rd(input logic [8:0] a);
    sfr_addr_i = a;
    #1;
    got = sfr_rdata_o;
  endtask

  task automatic expect_reg(input logic [8:0] a, input logic [7:0] e);
    rd(a);
    check(got, e);
  endtask

  // wait, bounded, for a control bit to fall back to zero
  task automatic poll(input int b);
    int n;
    n = 0;
    rd(CT);
    while (got[b] !== 1'b0 && n < 1000) begin
      @(negedge clock_i);
      rd(CT);
      n++;
    end
    check({7'h00, got[b]}, 8'h00);
  endtask

  task automatic nvm_write(input int a, input logic [7:0] d, input logic ok);
    wr(IX, a[7:0]);
    wr(BY, d);
    if (ok) begin
      put(CT, 8'h08);
    end
    wr(CT, 8'h0c);
    if (ok) begin
      mem[a % 32] = d;
      exp_starts++;
      poll(2);
    end
    check(starts[7:0], exp_starts[7:0]);
    wr(CT, 8'h00);
  endtask

  task automatic nvm_read(input int a);
    wr(IX, a[7:0]);
    put(CT, 8'h02);
    wr(CT, 8'h03);
    poll(0);
    expect_reg(BY, mem[a % 32][7:0]);
    wr(CT, 8'h00);
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #500_000;
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(negedge clock_i);
    rst_n_i = 1'b1;
    @(negedge clock_i);
    expect_reg(CT, 8'h00);
    expect_reg(IX, 8'h00);
    expect_reg(BY, 8'h00);
    expect_reg(9'h042, 8'h00);
    wr(IX, 8'hff);
    expect_reg(IX, 8'h1f);
    wr(CT, 8'hf0);
    expect_reg(CT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      tmr_slow = i[0];
      dat = $random(seed);
      nvm_write(addrs[i], dat[7:0], 1'b1);
    end
    // trigger without a stored permit must leave the byte alone
    nvm_write(31, ~mem[31][7:0], 1'b0);
    check({7'h00, nvm_irq_flag_o}, 8'h01);
    for (int k = 0; k < 8; k++) begin
      @(negedge clock_i);
      {irq_mask_i, global_irq_enable_i, stack_full_i} = k[2:0];
      #1;
      check({7'h00, irq_req_o}, {7'h00, k == 6});
    end
    @(negedge clock_i);
    irq_ack_i = 1'b1;
    #1;
    check({7'h00, global_irq_clear_o}, 8'h01);
    @(negedge clock_i);
    irq_ack_i = 1'b0;
    check({7'h00, nvm_irq_flag_o}, 8'h00);
    wr(BY, 8'ha5);
    wr(CT, 8'h01);
    repeat (8) @(negedge clock_i);
    expect_reg(BY, 8'ha5);
    expect_reg(CT, 8'h00);
    wr(CT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      nvm_read(addrs[i]);
    end
    give_verdict();
  end
endmodule // nac_ctrl_test
`default_nettype wire

// ==== verif/nac_timer_model.sv ====
// stand-in for the asynchronous write timer of the nvm block
// assumes start_i is a one-cycle pulse made from inputs set at negedge
`timescale 1ns/1ps
`default_nettype none
module nac_timer_model #(
  parameter int WAIT = 20
) (
  input  wire logic clock_i,
  input  wire logic start_i,
  input  wire logic slow_i,
  output logic      done_o
);
  int   cnt = 0;
  logic tog = 1'b0;
  assign done_o = tog;
  // done toggle off the clock edge
  // sampled late in the low phase so the start pulse has settled
  always @(negedge clock_i) begin
    #3;
    if (start_i === 1'b1) begin
      cnt = slow_i ? WAIT * 10 : WAIT;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        tog = ~tog;
      end
    end
  end
endmodule // nac_timer_model
`default_nettype wire
